// *** logic/eots_defines.svh ***
// register offsets, field positions and timing constants of the output test sequencer
`ifndef EOTS_DEFINES_SVH
`define EOTS_DEFINES_SVH
`define EOTS_CLK_HZ 25000000
`define EOTS_TICK_US 100
`define EOTS_TICK_CYC ((`EOTS_CLK_HZ / 1000000) * `EOTS_TICK_US)
`define EOTS_TICKS_PER_MS 10
`define EOTS_PWM_STEPS 8'hFF
`define EOTS_RPM_NUM 32'h00927C00
`define EOTS_ADR_CTRL 4'h0
`define EOTS_ADR_CMD 4'h1
`define EOTS_ADR_INTV 4'h2
`define EOTS_ADR_DWELL 4'h3
`define EOTS_ADR_PW 4'h4
`define EOTS_ADR_COUNT 4'h5
`define EOTS_ADR_SEL 4'h6
`define EOTS_ADR_STAT 4'h7
`define EOTS_ADR_REMAIN 4'h8
`define EOTS_ADR_RPM 4'h9
`define EOTS_ADR_G1MODE 4'hA
`define EOTS_ADR_G2MODE 4'hB
`define EOTS_ADR_G3MODE 4'hC
`define EOTS_ADR_PULSE 4'hD
`define EOTS_ADR_OUTS 4'hE
`define EOTS_CMD_ENABLE 0
`define EOTS_CMD_EXIT 1
`define EOTS_CMD_PUMP_ON 2
`define EOTS_CMD_PUMP_OFF 3
`define EOTS_CMD_COIL_START 4
`define EOTS_CMD_INJ_START 5
`define EOTS_CMD_STOP 6
`define EOTS_CMD_GEN_ENTER 7
`define EOTS_CMD_GEN_EXIT 8
`define EOTS_CTRL_SEQ 0
`define EOTS_CTRL_SEMI 1
`define EOTS_SEL_COIL_LSB 0
`define EOTS_SEL_INJ_LSB 4
`define EOTS_NCH 8
`define EOTS_NG1 8
`define EOTS_NG3 8
`define EOTS_G1_IDLE_LSB 4
`define EOTS_G1_TACH 3
`define EOTS_G1_PUMP 0
`endif

// *** logic/eots_pkg.sv ***
// types of the output test sequencer
package eots_pkg;
  typedef enum logic [2:0] {EOTS_IDLE, EOTS_COIL_DWELL, EOTS_COIL_WAIT, EOTS_INJ_OPEN,
    EOTS_INJ_WAIT} eots_run_t;
  typedef enum logic [1:0] {EOTS_OFF, EOTS_ON, EOTS_PULSED, EOTS_RSVD} eots_omode_t;
endpackage

// *** logic/eots_top.sv ***
// engine output test sequencer: coil, injector, pump and general output test logic
//
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`include "eots_defines.svh"
// Summary of operation
// - enable only with ignition on, zero speed
// - pump on command drives pump, sets ready
// - pump off command drops pump, clears ready
// - coil dwell time repeats every interval
// - single mode fires only selected coil
// - sequence fires first to selected, repeating
// - sequence dwell periods never overlap
// - start accepted only with valid settings
// - injector opens pulse width every interval
// - injection count register up to 65535
// - count down per injection, stop at zero
// - stop ends coil or injector test immediately
// - semi-sequential drives injectors in pairs
// - general outputs off, on or pulsed
// - fuel pump has no pulsed mode
// - spark outputs inverted in general test
// - spark outputs may stay high after exit
// - outputs ground switched except tach, idle valve, group 3, coils in coil test
// - general test in three output groups
// - report speed estimate from interval
module eots_top
  import eots_pkg::*;
(
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST_N,
  // engine status pins
  input wire logic IGN_ON,
  input wire logic RPM_ZERO,
  // normal engine control levels
  input wire logic [`EOTS_NCH-1:0] NORM_COIL,
  input wire logic [`EOTS_NCH-1:0] NORM_INJ,
  input wire logic [`EOTS_NG1-1:0] NORM_G1,
  input wire logic [`EOTS_NG3-1:0] NORM_G3,
  // register port
  input wire logic [3:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  // actuator pin drives, low level sinks current unless noted
  output logic [`EOTS_NCH-1:0] COIL_OUT,
  output logic [`EOTS_NCH-1:0] INJ_OUT,
  output logic [`EOTS_NG1-1:0] G1_OUT,
  output logic [`EOTS_NG3-1:0] G3_OUT,
  output logic TEST_ACTIVE
);
  logic ign_s1_ff, ign_s2_ff, rpm_s1_ff, rpm_s2_ff;
  logic test_en_ff, gen_ff, ready_ff, pump_ff, spark_hold_ff;
  logic seq_ff, semi_ff;
  logic [15:0] intv_ff, dwell_ff, pw_ff, count_ff, remain_ff;
  logic [2:0] coil_sel_ff, inj_sel_ff, cur_ff;
  logic [15:0] g1_mode_ff, g3_mode_ff;
  logic [15:0] g2_mode_ff [0:1];
  logic [7:0] duty_ff, per_ff;
  logic [15:0] tick_cnt_ff, ph_ff, ms_ff;
  logic [7:0] pwm_cnt_ff, per_cnt_ff;
  logic tick_ff, pwm_step_ff;
  eots_run_t run_ff;
  logic [15:0] rpm_ff;
  logic [`EOTS_NCH-1:0] coil_act, inj_act, g2c_act, g2i_act;
  logic [`EOTS_NG1-1:0] g1_act;
  logic [`EOTS_NG3-1:0] g3_act;
  logic pwm_hi, settings_ok, can_enable, wr_cmd;
  logic [31:0] nxt_rdata;

  // two flop synchronisers for pins
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ign_s1_ff <= 1'b0;
      ign_s2_ff <= 1'b0;
      rpm_s1_ff <= 1'b0;
      rpm_s2_ff <= 1'b0;
    end else begin
      ign_s1_ff <= IGN_ON;
      ign_s2_ff <= ign_s1_ff;
      rpm_s1_ff <= RPM_ZERO;
      rpm_s2_ff <= rpm_s1_ff;
    end
  end

  assign can_enable = ign_s2_ff && rpm_s2_ff;
  assign wr_cmd = WR && (ADDR == `EOTS_ADR_CMD);
  assign settings_ok = (intv_ff != 16'h0000) && (count_ff != 16'h0000) &&
    (dwell_ff != 16'h0000) && (pw_ff != 16'h0000) && (dwell_ff < intv_ff) &&
    (pw_ff < intv_ff);

  // 0.1 ms tick for test timing
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      tick_cnt_ff <= 16'h0000;
      tick_ff <= 1'b0;
    end else if (tick_cnt_ff == 16'(`EOTS_TICK_CYC - 1)) begin
      tick_cnt_ff <= 16'h0000;
      tick_ff <= 1'b1;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 16'h0001;
      tick_ff <= 1'b0;
    end
  end

  // millisecond counter from the tick
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ms_ff <= 16'h0000;
    end else if (tick_ff) begin
      ms_ff <= (ms_ff == 16'(`EOTS_TICKS_PER_MS - 1)) ? 16'h0000 : ms_ff + 16'h0001;
    end
  end

  // test mode enable and pump state
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      test_en_ff <= 1'b0;
      pump_ff <= 1'b0;
      ready_ff <= 1'b0;
      gen_ff <= 1'b0;
      spark_hold_ff <= 1'b0;
    end else begin
      if (!ign_s2_ff) begin
        test_en_ff <= 1'b0;
        pump_ff <= 1'b0;
        ready_ff <= 1'b0;
        gen_ff <= 1'b0;
      end else if (wr_cmd) begin
        if (WDATA[`EOTS_CMD_ENABLE] && can_enable) begin
          test_en_ff <= 1'b1;
        end
        if (WDATA[`EOTS_CMD_EXIT]) begin
          test_en_ff <= 1'b0;
          pump_ff <= 1'b0;
          ready_ff <= 1'b0;
          gen_ff <= 1'b0;
        end else if (test_en_ff) begin
          if (WDATA[`EOTS_CMD_PUMP_ON]) begin
            pump_ff <= 1'b1;
            ready_ff <= 1'b1;
          end else if (WDATA[`EOTS_CMD_PUMP_OFF]) begin
            pump_ff <= 1'b0;
            ready_ff <= 1'b0;
          end
          if (WDATA[`EOTS_CMD_GEN_ENTER] && run_ff == EOTS_IDLE) begin
            gen_ff <= 1'b1;
          end else if (WDATA[`EOTS_CMD_GEN_EXIT]) begin
            gen_ff <= 1'b0;
          end
        end
      end
      if (gen_ff) begin
        spark_hold_ff <= 1'b1;
      end
    end
  end

  // configuration registers
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      seq_ff <= 1'b0;
      semi_ff <= 1'b0;
      intv_ff <= 16'h0000;
      dwell_ff <= 16'h0000;
      pw_ff <= 16'h0000;
      count_ff <= 16'h0000;
      coil_sel_ff <= 3'h0;
      inj_sel_ff <= 3'h0;
      g1_mode_ff <= 16'h0000;
      g2_mode_ff[0] <= 16'h0000;
      g2_mode_ff[1] <= 16'h0000;
      g3_mode_ff <= 16'h0000;
      duty_ff <= 8'h80;
      per_ff <= 8'h01;
    end else if (WR) begin
      case (ADDR)
        `EOTS_ADR_CTRL: begin
          seq_ff <= WDATA[`EOTS_CTRL_SEQ];
          semi_ff <= WDATA[`EOTS_CTRL_SEMI];
        end
        `EOTS_ADR_INTV: intv_ff <= WDATA[15:0];
        `EOTS_ADR_DWELL: dwell_ff <= WDATA[15:0];
        `EOTS_ADR_PW: pw_ff <= WDATA[15:0];
        `EOTS_ADR_COUNT: count_ff <= WDATA[15:0];
        `EOTS_ADR_SEL: begin
          coil_sel_ff <= WDATA[`EOTS_SEL_COIL_LSB +: 3];
          inj_sel_ff <= WDATA[`EOTS_SEL_INJ_LSB +: 3];
        end
        `EOTS_ADR_G1MODE: g1_mode_ff <= WDATA[15:0];
        `EOTS_ADR_G2MODE: begin
          g2_mode_ff[0] <= WDATA[15:0];
          g2_mode_ff[1] <= WDATA[31:16];
        end
        `EOTS_ADR_G3MODE: g3_mode_ff <= WDATA[15:0];
        `EOTS_ADR_PULSE: begin
          duty_ff <= WDATA[7:0];
          per_ff <= (WDATA[15:8] == 8'h00) ? 8'h01 : WDATA[15:8];
        end
        default: begin
        end
      endcase
    end
  end

  // coil and injector sequencer, times in ms
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      run_ff <= EOTS_IDLE;
      ph_ff <= 16'h0000;
      cur_ff <= 3'h0;
      remain_ff <= 16'h0000;
    end else if (!test_en_ff || (wr_cmd && WDATA[`EOTS_CMD_STOP])) begin
      run_ff <= EOTS_IDLE;
      ph_ff <= 16'h0000;
    end else begin
      case (run_ff)
        EOTS_IDLE: begin
          if (wr_cmd && settings_ok && !gen_ff) begin
            ph_ff <= 16'h0000;
            if (WDATA[`EOTS_CMD_COIL_START]) begin
              run_ff <= EOTS_COIL_DWELL;
              cur_ff <= seq_ff ? 3'h0 : coil_sel_ff;
            end else if (WDATA[`EOTS_CMD_INJ_START]) begin
              run_ff <= EOTS_INJ_OPEN;
              cur_ff <= inj_sel_ff;
              remain_ff <= count_ff;
            end
          end
        end
        EOTS_COIL_DWELL, EOTS_COIL_WAIT: begin
          if (tick_ff && ms_ff == 16'(`EOTS_TICKS_PER_MS - 1)) begin
            ph_ff <= ph_ff + 16'h0001;
            if (ph_ff + 16'h0001 >= dwell_ff) begin
              run_ff <= EOTS_COIL_WAIT;
            end
            if (ph_ff + 16'h0001 >= intv_ff) begin
              ph_ff <= 16'h0000;
              run_ff <= EOTS_COIL_DWELL;
              if (seq_ff) begin
                cur_ff <= (cur_ff >= coil_sel_ff) ? 3'h0 : cur_ff + 3'h1;
              end
            end
          end
        end
        EOTS_INJ_OPEN, EOTS_INJ_WAIT: begin
          if (tick_ff && ms_ff == 16'(`EOTS_TICKS_PER_MS - 1)) begin
            ph_ff <= ph_ff + 16'h0001;
            if (run_ff == EOTS_INJ_OPEN && ph_ff + 16'h0001 >= pw_ff) begin
              run_ff <= EOTS_INJ_WAIT;
              remain_ff <= remain_ff - 16'h0001;
            end
            if (ph_ff + 16'h0001 >= intv_ff) begin
              ph_ff <= 16'h0000;
              run_ff <= (remain_ff == 16'h0000) ? EOTS_IDLE : EOTS_INJ_OPEN;
            end
          end
        end
        default: run_ff <= EOTS_IDLE;
      endcase
    end
  end

  // estimated speed in rpm, 9600 divided by the interval in ms, zero for a zero interval
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rpm_ff <= 16'h0000;
    end else begin
      rpm_ff <= (intv_ff == 16'h0000) ? 16'h0000 :
        16'(32'(`EOTS_RPM_NUM) / (32'(intv_ff) * 32'd1000));
    end
  end

  // pulse generator shared by pulsed general outputs
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      per_cnt_ff <= 8'h00;
      pwm_cnt_ff <= 8'h00;
      pwm_step_ff <= 1'b0;
    end else begin
      pwm_step_ff <= 1'b0;
      if (tick_ff) begin
        if (per_cnt_ff + 8'h01 >= per_ff) begin
          per_cnt_ff <= 8'h00;
          pwm_step_ff <= 1'b1;
        end else begin
          per_cnt_ff <= per_cnt_ff + 8'h01;
        end
      end
      if (pwm_step_ff) begin
        pwm_cnt_ff <= (pwm_cnt_ff == `EOTS_PWM_STEPS - 8'h01) ? 8'h00 : pwm_cnt_ff + 8'h01;
      end
    end
  end

  assign pwm_hi = pwm_cnt_ff < duty_ff;

  function automatic logic mode_act(input logic [1:0] m, input logic p, input logic nopulse);
    mode_act = (m == EOTS_ON) || (m == EOTS_PULSED && p && !nopulse);
  endfunction

  // active levels of the sequencer and the three general groups
  always_comb begin
    coil_act = '0;
    inj_act = '0;
    g1_act = '0;
    g2c_act = '0;
    g2i_act = '0;
    g3_act = '0;
    if (run_ff == EOTS_COIL_DWELL) begin
      coil_act[cur_ff] = 1'b1;
    end
    if (run_ff == EOTS_INJ_OPEN) begin
      inj_act[cur_ff] = 1'b1;
      if (semi_ff) begin
        inj_act[cur_ff ^ 3'h4] = 1'b1;
      end
    end
    for (int i = 0; i < `EOTS_NG1; i++) begin
      g1_act[i] = mode_act(g1_mode_ff[2*i +: 2], pwm_hi, i == `EOTS_G1_PUMP);
      g3_act[i] = mode_act(g3_mode_ff[2*i +: 2], pwm_hi, 1'b0);
      g2c_act[i] = mode_act(g2_mode_ff[0][2*i +: 2], pwm_hi, 1'b0);
      g2i_act[i] = mode_act(g2_mode_ff[1][2*i +: 2], pwm_hi, 1'b0);
    end
    if (!gen_ff) begin
      g1_act[`EOTS_G1_PUMP] = pump_ff;
    end
  end

  // output pins, active outputs sink to ground except tach, idle valve, group 3 and coils in coil test
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      COIL_OUT <= '0;
      INJ_OUT <= '1;
      G1_OUT <= '1;
      G3_OUT <= '0;
      TEST_ACTIVE <= 1'b0;
    end else begin
      TEST_ACTIVE <= test_en_ff;
      if (gen_ff) begin
        COIL_OUT <= ~g2c_act;
        INJ_OUT <= ~g2i_act;
        for (int i = 0; i < `EOTS_NG1; i++) begin
          G1_OUT[i] <= (i == `EOTS_G1_TACH || i >= `EOTS_G1_IDLE_LSB) ?
            g1_act[i] : ~g1_act[i];
        end
        G3_OUT <= g3_act;
      end else if (test_en_ff) begin
        COIL_OUT <= coil_act;
        INJ_OUT <= ~inj_act;
        G1_OUT <= {NORM_G1[`EOTS_NG1-1:1], ~pump_ff};
        G3_OUT <= NORM_G3;
      end else begin
        COIL_OUT <= NORM_COIL | (spark_hold_ff ? '1 : '0);
        INJ_OUT <= NORM_INJ;
        G1_OUT <= NORM_G1;
        G3_OUT <= NORM_G3;
      end
    end
  end

  // register read mux
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    case (ADDR)
      `EOTS_ADR_CTRL: nxt_rdata = {30'h0, semi_ff, seq_ff};
      `EOTS_ADR_INTV: nxt_rdata = {16'h0, intv_ff};
      `EOTS_ADR_DWELL: nxt_rdata = {16'h0, dwell_ff};
      `EOTS_ADR_PW: nxt_rdata = {16'h0, pw_ff};
      `EOTS_ADR_COUNT: nxt_rdata = {16'h0, count_ff};
      `EOTS_ADR_SEL: nxt_rdata = {25'h0, inj_sel_ff, 1'b0, coil_sel_ff};
      `EOTS_ADR_STAT: nxt_rdata = {24'h0, settings_ok, run_ff, gen_ff, can_enable,
        ready_ff, test_en_ff};
      `EOTS_ADR_REMAIN: nxt_rdata = {16'h0, remain_ff};
      `EOTS_ADR_RPM: nxt_rdata = {16'h0, rpm_ff};
      `EOTS_ADR_G1MODE: nxt_rdata = {16'h0, g1_mode_ff};
      `EOTS_ADR_G2MODE: nxt_rdata = {g2_mode_ff[1], g2_mode_ff[0]};
      `EOTS_ADR_G3MODE: nxt_rdata = {16'h0, g3_mode_ff};
      `EOTS_ADR_PULSE: nxt_rdata = {16'h0, per_ff, duty_ff};
      `EOTS_ADR_OUTS: nxt_rdata = {8'h0, G1_OUT, INJ_OUT, COIL_OUT};
      default: nxt_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      RDATA <= 32'h0000_0000;
    end else begin
      RDATA <= RD ? nxt_rdata : 32'h0000_0000;
    end
  end
endmodule

// *** verif/eots_top_properties.sv ***
// concurrent checks on the output test sequencer ports
`timescale 1ns/1ps
`include "eots_defines.svh"
module eots_top_props (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST_N,
  // register port
  input wire logic [3:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [31:0] RDATA,
  // normal levels and pin drives
  input wire logic [`EOTS_NCH-1:0] NORM_INJ,
  input wire logic [`EOTS_NG1-1:0] NORM_G1,
  input wire logic [`EOTS_NG3-1:0] NORM_G3,
  input wire logic [`EOTS_NCH-1:0] COIL_OUT,
  input wire logic [`EOTS_NCH-1:0] INJ_OUT,
  input wire logic [`EOTS_NG1-1:0] G1_OUT,
  input wire logic [`EOTS_NG3-1:0] G3_OUT,
  input wire logic TEST_ACTIVE
);
  logic hold_ff;
  logic semi_ff;
  wire logic cw = WR && ADDR == `EOTS_ADR_CMD;
  wire logic quiet = TEST_ACTIVE && !hold_ff;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  // general test leaves spark lines forced until reset
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) hold_ff <= 1'h0;
    else if (cw && WDATA[`EOTS_CMD_GEN_ENTER]) hold_ff <= 1'h1;
  end
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) semi_ff <= 1'h0;
    else if (WR && ADDR == `EOTS_ADR_CTRL) semi_ff <= WDATA[`EOTS_CTRL_SEMI];
  end
  chk_enable_gate: assert property (
    $rose(TEST_ACTIVE) |-> $past(cw && WDATA[`EOTS_CMD_ENABLE], 2))
    else $error("test mode rose without enable command");
  chk_rdata_quiet: assert property (!$past(RD) |-> RDATA == 32'h0)
    else $error("read data not zero outside answer cycle");
  chk_coil_single: assert property (
    quiet && $past(TEST_ACTIVE) |-> $onehot0(COIL_OUT))
    else $error("more than one coil charging");
  chk_stop_ends: assert property (
    cw && WDATA[`EOTS_CMD_STOP] && quiet
    |-> ##2 (COIL_OUT == 8'h00 && INJ_OUT == 8'hFF) [*4])
    else $error("test still firing after stop");
  chk_pump_on: assert property (
    cw && WDATA[`EOTS_CMD_PUMP_ON] && quiet |-> ##2 (!G1_OUT[`EOTS_G1_PUMP]) [*4])
    else $error("pump not driven after pump on");
  chk_pump_off: assert property (
    cw && WDATA[`EOTS_CMD_PUMP_OFF] && quiet |-> ##2 G1_OUT[`EOTS_G1_PUMP] [*4])
    else $error("pump still driven after pump off");
  chk_inj_pair: assert property (
    quiet && semi_ff && $past(TEST_ACTIVE) |-> INJ_OUT[3:0] == INJ_OUT[7:4])
    else $error("paired injectors differ");
  chk_pass_thru: assert property (
    !TEST_ACTIVE && !$past(TEST_ACTIVE) && $past(RST_N)
    |-> INJ_OUT == $past(NORM_INJ) && G3_OUT == $past(NORM_G3) && G1_OUT == $past(NORM_G1))
    else $error("outputs not under normal control");
endmodule
bind eots_top eots_top_props eots_top_props_i (.REF_CLK, .RST_N, .ADDR, .WDATA, .WR, .RD,
  .RDATA, .NORM_INJ, .NORM_G1, .NORM_G3, .COIL_OUT, .INJ_OUT, .G1_OUT, .G3_OUT, .TEST_ACTIVE);

// *** verif/eots_actuators.sv ***
// actuator bank model: counts coil charges and injector openings
`timescale 1ns/1ps
module eots_actuators (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pin drives
  input wire logic [7:0] coil,
  input wire logic [7:0] inj,
  // pulse counts
  output int coil_n,
  output int inj_n
);
  logic [7:0] coil_ff;
  logic [7:0] inj_ff;
  // coil charges on a high level, injector opens on a low level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      coil_ff <= 8'h00;
      inj_ff <= 8'hFF;
      coil_n <= 0;
      inj_n <= 0;
    end else begin
      coil_ff <= coil;
      inj_ff <= inj;
      coil_n <= coil_n + $countones(coil & ~coil_ff);
      inj_n <= inj_n + $countones(inj_ff & ~inj);
    end
  end
endmodule

// *** verif/tb.sv ***
// self-checking bench of the engine output test sequencer
`timescale 1ns/1ps
`include "eots_defines.svh"
module tb;
  logic REF_CLK = 0, RST_N = 0, IGN_ON = 0, RPM_ZERO = 0, WR = 0, RD = 0, rd_d = 0;
  logic [7:0] NORM_COIL = 0, NORM_INJ = 0, NORM_G1 = 0, NORM_G3 = 0;
  logic [3:0] ADDR = 0;
  logic [31:0] WDATA = 0;
  logic [31:0] RDATA;
  logic [7:0] COIL_OUT, INJ_OUT, G1_OUT, G3_OUT;
  logic TEST_ACTIVE;
  logic [31:0] exp_q[$];
  int fails = 0, n_compared = 0, cyc = 0, coil_n, inj_n, c0;
  eots_top eots_top_i (.REF_CLK, .RST_N, .IGN_ON, .RPM_ZERO, .NORM_COIL, .NORM_INJ,
    .NORM_G1, .NORM_G3, .ADDR, .WDATA, .WR, .RD, .RDATA, .COIL_OUT, .INJ_OUT, .G1_OUT,
    .G3_OUT, .TEST_ACTIVE);
  eots_actuators eots_actuators_i (.clk(REF_CLK), .rst_n(RST_N), .coil(COIL_OUT),
    .inj(INJ_OUT), .coil_n, .inj_n);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task finish_test();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task tick(input int n);
    repeat (n) @(posedge REF_CLK);
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge REF_CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'h1;
    @(posedge REF_CLK);
    WR <= 1'h0;
  endtask
  task rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge REF_CLK);
    ADDR <= a;
    RD <= 1'h1;
    exp_q.push_back(e);
    @(posedge REF_CLK);
    RD <= 1'h0;
  endtask
  task cmd(input int b);
    wr(`EOTS_ADR_CMD, 32'h1 << b);
  endtask
  task automatic wait_for(input bit on_inj, input logic [7:0] v, input bit eq);
    for (int k = 0; k < 30000 && (((on_inj ? INJ_OUT : COIL_OUT) === v) != eq); k++)
      @(posedge REF_CLK);
  endtask
  always @(posedge REF_CLK) rd_d <= RD;
  always @(negedge REF_CLK) begin
    if (rd_d) check(RDATA, exp_q.pop_front());
  end
  always @(posedge REF_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      fails++;
      finish_test();
    end
  end
  initial begin
    forever #20 REF_CLK = ~REF_CLK;
  end
  initial begin
    void'($urandom(32'h8A61));
    tick(8);
    RST_N <= 1'h1;
    @(posedge REF_CLK);
    {NORM_COIL, NORM_INJ, NORM_G1, NORM_G3} <= $urandom;
    cmd(`EOTS_CMD_ENABLE);
    cmd(`EOTS_CMD_PUMP_ON);
    tick(4);
    check(TEST_ACTIVE, 32'h0);
    check(G1_OUT, NORM_G1);
    rd(`EOTS_ADR_STAT, 32'h0);
    IGN_ON <= 1'h1;
    RPM_ZERO <= 1'h1;
    tick(4);
    rd(`EOTS_ADR_STAT, 32'h4);
    cmd(`EOTS_CMD_ENABLE);
    tick(2);
    check(TEST_ACTIVE, 32'h1);
    wr(`EOTS_ADR_CTRL, 32'h1);
    wr(`EOTS_ADR_INTV, 32'h2);
    wr(`EOTS_ADR_DWELL, 32'h2);
    wr(`EOTS_ADR_PW, 32'h1);
    wr(`EOTS_ADR_COUNT, 32'hFFFF);
    wr(`EOTS_ADR_SEL, 32'h12);
    rd(`EOTS_ADR_COUNT, 32'hFFFF);
    rd(`EOTS_ADR_RPM, `EOTS_RPM_NUM / 32'd2000);
    rd(`EOTS_ADR_STAT, 32'h5);
    cmd(`EOTS_CMD_COIL_START);
    tick(4);
    check(COIL_OUT, 8'h00);
    cmd(`EOTS_CMD_PUMP_ON);
    wr(`EOTS_ADR_DWELL, 32'h1);
    rd(`EOTS_ADR_STAT, 32'h87);
    c0 = coil_n;
    cmd(`EOTS_CMD_COIL_START);
    wait_for(1'b0, 8'h00, 1'b0);
    check(COIL_OUT, 8'h01);
    wait_for(1'b0, 8'h00, 1'b1);
    tick(2);
    check(coil_n - c0, 32'h1);
    cmd(`EOTS_CMD_STOP);
    wr(`EOTS_ADR_CTRL, 32'h2);
    wr(`EOTS_ADR_COUNT, 32'h1);
    c0 = inj_n;
    cmd(`EOTS_CMD_INJ_START);
    wait_for(1'b1, 8'hFF, 1'b0);
    check(INJ_OUT, 8'hDD);
    wait_for(1'b1, 8'hFF, 1'b1);
    // let the interval end pass, the run must stop with no further opening
    tick(25010);
    rd(`EOTS_ADR_REMAIN, 32'h0);
    rd(`EOTS_ADR_STAT, 32'h87);
    check(inj_n - c0, 32'h2);
    wr(`EOTS_ADR_COUNT, 32'h3);
    cmd(`EOTS_CMD_INJ_START);
    wait_for(1'b1, 8'hFF, 1'b0);
    cmd(`EOTS_CMD_STOP);
    tick(3);
    check(INJ_OUT, 8'hFF);
    rd(`EOTS_ADR_REMAIN, 32'h3);
    rd(`EOTS_ADR_STAT, 32'h87);
    cmd(`EOTS_CMD_PUMP_OFF);
    tick(4);
    check(G1_OUT[`EOTS_G1_PUMP], 32'h1);
    rd(`EOTS_ADR_STAT, 32'h85);
    cmd(`EOTS_CMD_GEN_ENTER);
    wr(`EOTS_ADR_PULSE, 32'h01FF);
    wr(`EOTS_ADR_G1MODE, 32'h46);
    wr(`EOTS_ADR_G2MODE, 32'h1);
    wr(`EOTS_ADR_G3MODE, 32'h9);
    tick(4);
    check(G1_OUT, 8'h0D);
    check(COIL_OUT, 8'hFE);
    check(G3_OUT, 8'h03);
    check(INJ_OUT, 8'hFF);
    rd(`EOTS_ADR_OUTS, 32'h000DFFFE);
    wr(`EOTS_ADR_PULSE, 32'h0100);
    tick(4);
    check(G3_OUT, 8'h01);
    cmd(`EOTS_CMD_GEN_EXIT);
    cmd(`EOTS_CMD_EXIT);
    wr(4'hF, 32'hFFFF);
    rd(4'hF, 32'h0);
    tick(4);
    check(TEST_ACTIVE, 32'h0);
    check(COIL_OUT, 8'hFF);
    check(INJ_OUT, NORM_INJ);
    // a power cycle releases the spark lines
    RST_N <= 1'h0;
    tick(2);
    RST_N <= 1'h1;
    tick(3);
    check(COIL_OUT, NORM_COIL);
    check(TEST_ACTIVE, 32'h0);
    finish_test();
  end
endmodule
